// >>> core/kpsm_defines.svh
// timing counts, passcodes, field limits and message codes for the setup menu controller
// assumes a 100 MHz ref_clk
`ifndef KPSM_DEFINES_SVH
`define KPSM_DEFINES_SVH
`define KPSM_CLK_HZ 100_000_000
`define KPSM_IDLE_MIN 5
`define KPSM_IDLE_CYCLES (64'(`KPSM_IDLE_MIN) * 60 * `KPSM_CLK_HZ)
`define KPSM_HOLD_MS 2000
`define KPSM_HOLD_CYCLES (`KPSM_HOLD_MS * (`KPSM_CLK_HZ / 1000))
`define KPSM_ELAPSED_MS 1000
`define KPSM_ELAPSED_CYCLES (`KPSM_ELAPSED_MS * (`KPSM_CLK_HZ / 1000))
`define KPSM_SEL_CODE 16'h4523
`define KPSM_PROG_CODE 16'h3254
`define KPSM_TRIES 2'h3
`define KPSM_SPAN_C 16'h1000
`define KPSM_SPAN_F 16'h2000
`define KPSM_MSG_NONE 5'h00
`define KPSM_MSG_ELAPSED 5'h01
`define KPSM_MSG_PASSCODE 5'h02
`define KPSM_MSG_ERROR 5'h03
`define KPSM_MSG_SAVING 5'h04
`define KPSM_MSG_GROUP 5'h05
`define KPSM_MSG_CTRL_TYPE 5'h06
`define KPSM_MSG_HYST 5'h07
`define KPSM_MSG_PBAND 5'h08
`define KPSM_MSG_RESET 5'h09
`define KPSM_MSG_RATE 5'h0A
`define KPSM_MSG_UNITS 5'h0B
`define KPSM_MSG_DISP_CHOICE 5'h0C
`define KPSM_MSG_DISP_TIME 5'h0D
`define KPSM_MSG_HEAT_COOL 5'h0E
`define KPSM_MSG_RATE_BASE 5'h0F
`define KPSM_MSG_PROG_SELECT 5'h10
`define KPSM_MSG_SUBGROUP 5'h11
`endif

// >>> core/kpsm_pkg.sv
// types shared by the setup menu controller and its helpers
// constants live in kpsm_defines.svh
package kpsm_pkg;
    typedef struct packed {
        logic setup;
        logic reset;
        logic adjust_toggle;
        logic digit_advance;
        logic aux;
    } kpsm_keys_t;
    typedef enum logic [1:0] {
        KPSM_VIEW_PROCESS,
        KPSM_VIEW_TARGET,
        KPSM_VIEW_COMBINED
    } kpsm_view_t;
    typedef struct packed {
        logic pid_mode;
        logic fahrenheit;
        kpsm_view_t view;
        logic cooling;
        logic [15:0] hysteresis;
        logic [15:0] pband;
        logic [15:0] reset_term;
        logic [15:0] rate_term;
        logic [15:0] display_hold_time;
        logic [15:0] rate_base;
    } kpsm_params_t;
endpackage

// >>> core/kpsm_key_events.sv
// key edge detector: press pulses per key and a flag for any key change
// assumes keys are debounced and synchronous to ref_clk
module kpsm_key_events (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire kpsm_pkg::kpsm_keys_t keys,
    output kpsm_pkg::kpsm_keys_t press,
    output logic activity
);
    kpsm_pkg::kpsm_keys_t prev;
    kpsm_pkg::kpsm_keys_t next_prev;
    always_comb begin
        next_prev = keys;
    end
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            prev <= '0;
        end else begin
            prev <= next_prev;
        end
    end
    assign press = keys & ~prev;
    assign activity = (keys != prev);
endmodule

// >>> core/kpsm_digit_editor.sv
// digit-by-digit bcd editor with increment/decrement toggle on each new adjust press
// assumes load pulses when a value step opens
module kpsm_digit_editor #(
    parameter int DIGITS = 4
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic load,
    input wire logic [4*DIGITS-1:0] load_value,
    input wire logic enable,
    input wire logic adjust_press,
    input wire logic adjust_held,
    input wire logic advance_press,
    input wire logic repeat_tick,
    output logic [4*DIGITS-1:0] value,
    output logic [DIGITS-1:0] flash
);
    logic [4*DIGITS-1:0] next_value;
    logic [$clog2(DIGITS)-1:0] pos;
    logic [$clog2(DIGITS)-1:0] next_pos;
    logic down;
    logic next_down;
    logic step;
    logic [3:0] cur;
    always_comb begin
        next_value = value;
        next_pos = pos;
        next_down = down;
        cur = value[pos*4 +: 4];
        step = enable && (adjust_press || (adjust_held && repeat_tick));
        if (load) begin
            next_value = load_value;
            next_pos = '0;
            next_down = 1'b1;
        end else if (enable) begin
            if (adjust_press) begin
                next_down = ~down;
            end
            if (step) begin
                if (next_down) begin
                    next_value[pos*4 +: 4] = (cur == 4'h0) ? 4'h9 : cur - 4'h1;
                end else begin
                    next_value[pos*4 +: 4] = (cur == 4'h9) ? 4'h0 : cur + 4'h1;
                end
            end
            if (advance_press) begin
                next_pos = (pos == DIGITS[$clog2(DIGITS)-1:0] - 1'b1) ? '0 : pos + 1'b1;
            end
        end
    end
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            value <= '0;
            pos <= '0;
            down <= 1'b1;
        end else begin
            value <= next_value;
            pos <= next_pos;
            down <= next_down;
        end
    end
    genvar g;
    generate
        for (g = 0; g < DIGITS; g++) begin : g_flash
            assign flash[g] = enable && (pos == g);
        end
    endgenerate
endmodule

// >>> core/kpsm_setup_menu.sv
// front-panel setup menu: long-hold entry, passcode, groups, controller parameters, save exit
// assumes debounced synchronous keys and an external nonvolatile writer taking save_strobe
`include "kpsm_defines.svh"
module kpsm_setup_menu #(
    parameter longint IDLE_CYCLES = `KPSM_IDLE_CYCLES,
    parameter int HOLD_CYCLES = `KPSM_HOLD_CYCLES,
    parameter int ELAPSED_CYCLES = `KPSM_ELAPSED_CYCLES,
    parameter int REPEAT_CYCLES = 25_000_000
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire kpsm_pkg::kpsm_keys_t keys,
    input wire kpsm_pkg::kpsm_params_t stored_params,
    input wire logic profile_running,
    output logic in_setup,
    output logic [4:0] message,
    output logic [15:0] shown_value,
    output logic [3:0] flash,
    output logic save_strobe,
    output kpsm_pkg::kpsm_params_t save_params,
    output kpsm_pkg::kpsm_params_t active_params,
    output logic prog_select_mode,
    output logic target_visible,
    output logic [15:0] pband_span
);
    typedef enum logic [4:0] {
        S_RUN, S_HOLD_ELAPSED, S_HOLD_PROMPT, S_PASSCODE, S_GROUP, S_SELECT,
        S_CTRL_TYPE, S_HYST, S_PBAND, S_RESET, S_RATE, S_UNITS, S_DISP_TIME,
        S_DISP_CHOICE, S_HEAT_COOL, S_RATE_BASE, S_SUBGROUP, S_SAVING
    } kpsm_state_t;
    kpsm_state_t state, next_state;
    kpsm_pkg::kpsm_params_t edit, next_edit;
    kpsm_pkg::kpsm_keys_t press;
    logic activity;
    logic [31:0] timer, next_timer, rep, next_rep;
    logic [35:0] idle, next_idle;
    logic [1:0] digits, next_digits, tries, next_tries, group, next_group;
    logic [15:0] code, next_code, load_value, ed_value, cand;
    logic code_bad, next_code_bad, next_save, load, edit_en, any_press, code_ok;
    logic [2:0] key_digit;

    kpsm_key_events u_events (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .keys(keys),
        .press(press),
        .activity(activity)
    );

    kpsm_digit_editor #(.DIGITS(4)) u_editor (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .load(load),
        .load_value(load_value),
        .enable(edit_en),
        .adjust_press(press.adjust_toggle),
        .adjust_held(keys.adjust_toggle),
        .advance_press(press.digit_advance),
        .repeat_tick(rep == 32'h0000_0000),
        .value(ed_value),
        .flash(flash)
    );

    // each key carries one passcode digit value
    always_comb begin
        key_digit = 3'h0;
        if (press.aux) key_digit = 3'h1;
        if (press.digit_advance) key_digit = 3'h2;
        if (press.adjust_toggle) key_digit = 3'h3;
        if (press.reset) key_digit = 3'h4;
        if (press.setup) key_digit = 3'h5;
    end
    assign any_press = (press != '0);
    assign edit_en = (state == S_HYST) || (state == S_PBAND) || (state == S_RESET) ||
        (state == S_RATE) || (state == S_DISP_TIME) || (state == S_RATE_BASE);
    assign cand = {code[11:0], 1'b0, key_digit};
    assign code_ok = (cand == (`KPSM_PROG_CODE >> (4 * (3 - digits)))) ||
        (cand == (`KPSM_SEL_CODE >> (4 * (3 - digits))));

    always_comb begin
        next_state = state;
        next_edit = edit;
        next_timer = timer + 32'h0000_0001;
        next_idle = idle + 36'h0_0000_0001;
        next_rep = (keys.adjust_toggle && rep != 32'h0000_0000) ? rep - 32'h0000_0001 : REPEAT_CYCLES[31:0];
        next_digits = digits;
        next_tries = tries;
        next_group = group;
        next_code = code;
        next_code_bad = code_bad;
        next_save = 1'b0;
        load = 1'b0;
        load_value = 16'h0000;
        if (state == S_RUN || activity) begin
            next_idle = 36'h0_0000_0000;
        end
        // writes back the editor value when setup is pressed to leave a numeric step
        if (press.setup) begin
            unique case (state)
                S_HYST: next_edit.hysteresis = ed_value;
                S_PBAND: next_edit.pband = ed_value;
                S_RESET: next_edit.reset_term = ed_value;
                S_RATE: next_edit.rate_term = ed_value;
                S_DISP_TIME: next_edit.display_hold_time = ed_value;
                S_RATE_BASE: next_edit.rate_base = ed_value;
                default: ;
            endcase
        end
        unique case (state)
            S_RUN: begin
                next_timer = 32'h0000_0000;
                next_edit = stored_params;
                if (keys.setup) begin
                    next_state = S_HOLD_ELAPSED;
                end
            end
            S_HOLD_ELAPSED: begin
                if (!keys.setup) begin
                    next_state = S_RUN;
                end else if (timer >= ELAPSED_CYCLES[31:0]) begin
                    next_state = S_HOLD_PROMPT;
                    next_timer = 32'h0000_0000;
                end
            end
            S_HOLD_PROMPT: begin
                if (!keys.setup && timer < HOLD_CYCLES[31:0]) begin
                    next_state = S_RUN;
                end else if (timer >= HOLD_CYCLES[31:0]) begin
                    next_state = S_PASSCODE;
                    next_tries = 2'h0;
                    next_digits = 2'h0;
                    next_code = 16'h0000;
                    next_code_bad = 1'b0;
                end
            end
            S_PASSCODE: begin
                // the first release of the entry hold is not a digit; only new presses count
                if (any_press) begin
                    next_code = cand;
                    next_digits = digits + 2'h1;
                    if (!code_ok) next_code_bad = 1'b1;
                    if (digits == 2'h3) begin
                        next_digits = 2'h0;
                        next_code = 16'h0000;
                        next_code_bad = 1'b0;
                        if (cand == `KPSM_PROG_CODE) begin
                            next_state = S_GROUP;
                            next_group = 2'h0;
                        end else if (cand == `KPSM_SEL_CODE) begin
                            next_state = S_SELECT;
                        end else if (tries == `KPSM_TRIES - 2'h1) begin
                            next_state = S_RUN;
                        end else begin
                            next_tries = tries + 2'h1;
                        end
                    end
                end
            end
            S_GROUP: begin
                if (press.adjust_toggle) begin
                    next_group = group + 2'h1;
                end else if (press.setup) begin
                    next_state = (group == 2'h0) ? S_CTRL_TYPE : S_SUBGROUP;
                end
            end
            S_SUBGROUP: if (press.setup) next_state = S_GROUP;
            S_SELECT: if (press.reset) next_state = S_RUN;
            S_CTRL_TYPE: begin
                if (press.adjust_toggle) next_edit.pid_mode = ~edit.pid_mode;
                if (press.setup) begin
                    next_state = edit.pid_mode ? S_PBAND : S_HYST;
                    load = 1'b1;
                    load_value = edit.pid_mode ? edit.pband : edit.hysteresis;
                end
            end
            S_HYST, S_RATE: if (press.setup) next_state = S_UNITS;
            S_PBAND: begin
                if (press.setup) begin
                    next_state = S_RESET;
                    load = 1'b1;
                    load_value = edit.reset_term;
                end
            end
            S_RESET: begin
                if (press.setup) begin
                    next_state = S_RATE;
                    load = 1'b1;
                    load_value = edit.rate_term;
                end
            end
            S_UNITS: begin
                if (press.adjust_toggle) next_edit.fahrenheit = ~edit.fahrenheit;
                if (press.setup) next_state = S_DISP_CHOICE;
            end
            S_DISP_CHOICE: begin
                if (press.adjust_toggle) begin
                    unique case (edit.view)
                        kpsm_pkg::KPSM_VIEW_PROCESS: next_edit.view = kpsm_pkg::KPSM_VIEW_TARGET;
                        kpsm_pkg::KPSM_VIEW_TARGET: next_edit.view = kpsm_pkg::KPSM_VIEW_COMBINED;
                        default: next_edit.view = kpsm_pkg::KPSM_VIEW_PROCESS;
                    endcase
                end
                if (press.setup) begin
                    next_state = S_DISP_TIME;
                    load = 1'b1;
                    load_value = edit.display_hold_time;
                end
            end
            S_DISP_TIME: if (press.setup) next_state = S_HEAT_COOL;
            S_HEAT_COOL: begin
                if (press.adjust_toggle) next_edit.cooling = ~edit.cooling;
                if (press.setup) begin
                    next_state = S_RATE_BASE;
                    load = 1'b1;
                    load_value = edit.rate_base;
                end
            end
            S_RATE_BASE: begin
                if (press.setup) begin
                    next_state = S_GROUP;
                    next_group = 2'h0;
                end
            end
            S_SAVING: if (timer >= ELAPSED_CYCLES[31:0]) next_state = S_RUN;
        endcase
        // the reset key is a passcode digit, so its hold exit is only armed past passcode entry
        if (state != S_RUN && state != S_HOLD_ELAPSED && state != S_HOLD_PROMPT &&
            state != S_PASSCODE && state != S_SAVING && state != S_SELECT) begin
            if (!keys.reset) next_timer = 32'h0000_0000;
            if (keys.reset && timer >= HOLD_CYCLES[31:0]) begin
                next_state = S_SAVING;
                next_save = 1'b1;
                next_timer = 32'h0000_0000;
            end
        end
        if (state != S_RUN && state != S_SAVING && idle >= IDLE_CYCLES[35:0]) begin
            next_state = S_RUN;
            next_save = 1'b0;
        end
        if (next_state != state && next_state != S_SAVING) begin
            next_timer = 32'h0000_0000;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= S_RUN;
            edit <= '0;
            timer <= 32'h0000_0000;
            idle <= 36'h0_0000_0000;
            rep <= 32'h0000_0000;
            digits <= 2'h0;
            tries <= 2'h0;
            group <= 2'h0;
            code <= 16'h0000;
            code_bad <= 1'b0;
            save_strobe <= 1'b0;
            save_params <= '0;
        end else begin
            state <= next_state;
            edit <= next_edit;
            timer <= next_timer;
            idle <= next_idle;
            rep <= next_rep;
            digits <= next_digits;
            tries <= next_tries;
            group <= next_group;
            code <= next_code;
            code_bad <= next_code_bad;
            save_strobe <= next_save;
            save_params <= next_save ? edit : save_params;
        end
    end

    always_comb begin
        unique case (state)
            S_HOLD_ELAPSED: message = `KPSM_MSG_ELAPSED;
            S_HOLD_PROMPT: message = `KPSM_MSG_PASSCODE;
            S_PASSCODE: message = code_bad ? `KPSM_MSG_ERROR : `KPSM_MSG_PASSCODE;
            S_GROUP: message = `KPSM_MSG_GROUP;
            S_SUBGROUP: message = `KPSM_MSG_SUBGROUP;
            S_SELECT: message = `KPSM_MSG_PROG_SELECT;
            S_CTRL_TYPE: message = `KPSM_MSG_CTRL_TYPE;
            S_HYST: message = `KPSM_MSG_HYST;
            S_PBAND: message = `KPSM_MSG_PBAND;
            S_RESET: message = `KPSM_MSG_RESET;
            S_RATE: message = `KPSM_MSG_RATE;
            S_UNITS: message = `KPSM_MSG_UNITS;
            S_DISP_TIME: message = `KPSM_MSG_DISP_TIME;
            S_DISP_CHOICE: message = `KPSM_MSG_DISP_CHOICE;
            S_HEAT_COOL: message = `KPSM_MSG_HEAT_COOL;
            S_RATE_BASE: message = `KPSM_MSG_RATE_BASE;
            S_SAVING: message = `KPSM_MSG_SAVING;
            default: message = `KPSM_MSG_NONE;
        endcase
        unique case (state)
            S_GROUP: shown_value = {14'h0000, group};
            S_CTRL_TYPE: shown_value = {15'h0000, edit.pid_mode};
            S_UNITS: shown_value = {15'h0000, edit.fahrenheit};
            S_DISP_CHOICE: shown_value = {14'h0000, edit.view};
            S_HEAT_COOL: shown_value = {15'h0000, edit.cooling};
            S_HOLD_ELAPSED: shown_value = 16'h0000;
            default: shown_value = edit_en ? ed_value : 16'h0000;
        endcase
    end

    assign in_setup = (state != S_RUN);
    assign prog_select_mode = (state == S_SELECT);
    assign active_params = stored_params;
    assign target_visible = (stored_params.view == kpsm_pkg::KPSM_VIEW_TARGET) ||
        ((stored_params.view == kpsm_pkg::KPSM_VIEW_COMBINED) && profile_running);
    assign pband_span = stored_params.fahrenheit ? `KPSM_SPAN_F : `KPSM_SPAN_C;
endmodule

// >>> dv/kpsm_operator.sv
// operator model: presses, holds and releases front-panel keys
// assumes keys are sampled on the rising edge of ref_clk
module kpsm_operator (
    input wire logic ref_clk,
    output kpsm_pkg::kpsm_keys_t keys
);
    timeunit 1ns;
    timeprecision 1ps;
    initial keys = '0;
    task automatic down(input int b);
        @(posedge ref_clk);
        #1 keys[b] = 1'b1;
    endtask
    // released keys read as not pressed, so all go low together
    task automatic up();
        @(posedge ref_clk);
        #1 keys = '0;
        repeat (3) @(posedge ref_clk);
    endtask
    task automatic press(input int b, input int n);
        down(b);
        repeat (n - 1) @(posedge ref_clk);
        up();
    endtask
endmodule

// >>> dv/kpsm_setup_menu_properties.sv
// port assertions for the setup menu controller
// assumes shortened idle count handed on by the bind
`include "kpsm_defines.svh"
module kpsm_setup_menu_properties #(
    parameter longint IDLE_CYCLES = 200
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire kpsm_pkg::kpsm_keys_t keys,
    input wire kpsm_pkg::kpsm_params_t stored_params,
    input wire logic profile_running,
    input wire logic in_setup,
    input wire logic [4:0] message,
    input wire logic [3:0] flash,
    input wire logic save_strobe,
    input wire kpsm_pkg::kpsm_params_t active_params,
    input wire logic prog_select_mode,
    input wire logic target_visible,
    input wire logic [15:0] pband_span
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);
    kpsm_pkg::kpsm_keys_t prev_keys, next_prev_keys;
    int idle, next_idle;
    always_comb begin
        next_prev_keys = keys;
        next_idle = (!in_setup || keys != prev_keys) ? 0 : idle + 1;
    end
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            prev_keys <= '0;
            idle <= 0;
        end else begin
            prev_keys <= next_prev_keys;
            idle <= next_idle;
        end
    end
    save_pulse_a: assert property (save_strobe |=> !save_strobe) else $error("long save");
    save_msg_a: assert property (save_strobe |-> in_setup && message == `KPSM_MSG_SAVING)
        else $error("save off saving");
    idle_bound_a: assert property (idle < IDLE_CYCLES + 4) else $error("idle overrun");
    stored_act_a: assert property (active_params == stored_params) else $error("edit acts");
    span_a: assert property (!in_setup && !$past(in_setup) |->
        pband_span == (stored_params.fahrenheit ? 16'h2000 : 16'h1000)) else $error("bad span");
    target_a: assert property (!in_setup && !$past(in_setup) |-> target_visible ==
        (stored_params.view == kpsm_pkg::KPSM_VIEW_TARGET || stored_params.view == kpsm_pkg::KPSM_VIEW_COMBINED
        && profile_running)) else $error("bad target view");
    entry_a: assert property ($rose(in_setup) |-> keys.setup && message == `KPSM_MSG_ELAPSED)
        else $error("bad entry");
    select_a: assert property (prog_select_mode |-> in_setup) else $error("select outside");
    flash_a: assert property ($onehot0(flash)) else $error("flash not one-hot");
    cover property (save_strobe);
    cover property ($rose(prog_select_mode));
    cover property (message == `KPSM_MSG_ERROR);
endmodule
bind kpsm_setup_menu kpsm_setup_menu_properties #(.IDLE_CYCLES(IDLE_CYCLES)) u_props (
    .ref_clk(ref_clk), .arst_n(arst_n), .keys(keys), .stored_params(stored_params),
    .profile_running(profile_running), .in_setup(in_setup), .message(message), .flash(flash),
    .save_strobe(save_strobe), .active_params(active_params), .prog_select_mode(prog_select_mode),
    .target_visible(target_visible), .pband_span(pband_span));

// >>> dv/kpsm_setup_menu_test.sv
// self-checking bench for the setup menu controller
// assumes short counts: idle 200, hold 20, elapsed 10, repeat 5
`include "kpsm_defines.svh"
module kpsm_setup_menu_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int IDLE = 200;
    logic ref_clk, arst_n, profile_running, in_setup, save_strobe, prog_select_mode, target_visible;
    kpsm_pkg::kpsm_keys_t keys;
    kpsm_pkg::kpsm_params_t stored_params, save_params;
    logic [4:0] message;
    logic [15:0] shown_value, pband_span;
    logic [3:0] flash;
    int n_errors = 0;
    int cmp_count = 0;
    int n_saves = 0;
    int cyc = 0;
    kpsm_operator u_op (.ref_clk(ref_clk), .keys(keys));
    kpsm_setup_menu #(.IDLE_CYCLES(IDLE), .HOLD_CYCLES(20), .ELAPSED_CYCLES(10), .REPEAT_CYCLES(5)) u_dut (
        .ref_clk(ref_clk), .arst_n(arst_n), .keys(keys), .stored_params(stored_params),
        .profile_running(profile_running), .in_setup(in_setup), .message(message), .shown_value(shown_value),
        .flash(flash), .save_strobe(save_strobe), .save_params(save_params), .active_params(),
        .prog_select_mode(prog_select_mode), .target_visible(target_visible), .pband_span(pband_span));
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic final_report();
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // digit d is entered by key bit d-1
    task automatic code(input logic [15:0] c);
        for (int i = 3; i >= 0; i--) begin
            u_op.press(int'(c[4*i+:4]) - 1, 2);
            #1;
            if (i > 0) check("good digit", 16'(message), 16'(`KPSM_MSG_PASSCODE));
        end
    endtask
    task automatic enter();
        u_op.down(4);
        tick(5);
        check("entry msg", 16'(message), 16'(`KPSM_MSG_ELAPSED));
        tick(20);
        check("prompt msg", 16'(message), 16'(`KPSM_MSG_PASSCODE));
        tick(10);
        u_op.up();
    endtask
    task automatic t_view();
        for (int i = 0; i < 6; i++) begin
            stored_params.view = kpsm_pkg::kpsm_view_t'(i / 2);
            stored_params.fahrenheit = i[0];
            profile_running = i[0];
            tick(2);
            check("span", pband_span, i[0] ? 16'h2000 : 16'h1000);
            check("target", 16'(target_visible), 16'(i / 2 == 1 || i == 5));
        end
        stored_params.fahrenheit = 1'b0;
    endtask
    task automatic t_wrong();
        enter();
        repeat (3) begin
            u_op.press(0, 2);
            tick(1);
            check("bad digit", 16'(message), 16'(`KPSM_MSG_ERROR));
            repeat (3) u_op.press(0, 2);
        end
        tick(2);
        check("tries out", 16'(in_setup), 16'h0000);
    endtask
    task automatic t_select();
        enter();
        code(16'h4523);
        tick(1);
        check("select", 16'(prog_select_mode), 16'h0001);
        u_op.press(3, 2);
        tick(1);
        check("select out", 16'(in_setup), 16'h0000);
    endtask
    task automatic t_idle();
        enter();
        tick(IDLE + 10);
        check("timeout", 16'(in_setup), 16'h0000);
        check("no save", 16'(n_saves), 16'h0000);
    endtask
    task automatic edit();
        logic [15:0] v0, d;
        logic [3:0] f0;
        v0 = shown_value;
        f0 = flash;
        d = '0;
        for (int i = 0; i < 4; i++) if (f0[i]) d = 16'h0001 << (4 * i);
        u_op.press(2, 1);
        tick(1);
        check("inc", shown_value, v0 + d);
        u_op.press(2, 1);
        tick(1);
        check("dec", shown_value, v0);
        u_op.press(1, 1);
        tick(1);
        check("advance", 16'(flash), 16'(f0[3] ? 4'h1 : f0 << 1));
        u_op.press(2, 6);
        tick(1);
        check("repeat", shown_value, v0 + (d << 5));
    endtask
    task automatic t_prog();
        logic [4:0] seq [17] = '{5'h06, 5'h07, 5'h0B, 5'h0C, 5'h0D, 5'h0E, 5'h0F, 5'h05, 5'h06,
            5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h0E, 5'h0F};
        int adj [17] = '{1, 0, 1, 3, 0, 1, 0, 0, 1, 0, 0, 0, 0, 0, 0, 0, 0};
        logic [15:0] s0;
        enter();
        code(16'h3254);
        tick(1);
        check("groups", 16'(message), 16'(`KPSM_MSG_GROUP));
        s0 = shown_value;
        repeat (4) u_op.press(2, 1);
        tick(1);
        check("group wrap", shown_value, s0);
        u_op.press(4, 1);
        tick(1);
        for (int i = 0; i < 17; i++) begin
            check("step", 16'(message), 16'(seq[i]));
            s0 = shown_value;
            repeat (adj[i]) u_op.press(2, 1);
            tick(1);
            if (adj[i] == 3) check("choice wrap", shown_value, s0);
            if (i == 6) edit();
            u_op.press(4, 1);
            tick(1);
        end
        u_op.press(3, 24);
        #1;
        check("saving msg", 16'(message), 16'(`KPSM_MSG_SAVING));
        tick(15);
        check("save exit", 16'(in_setup), 16'h0000);
        check("saves", 16'(n_saves), 16'h0001);
        check("units kept", 16'({save_params.fahrenheit, save_params.cooling}), 16'h0003);
        check("base kept", save_params.rate_base, 16'h1254);
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc++;
        if (save_strobe === 1'b1) n_saves++;
        if (cyc == 20000) begin
            n_errors++;
            final_report();
        end
    end
    initial begin
        arst_n = 1'b0;
        profile_running = 1'b0;
        stored_params = '0;
        stored_params.pid_mode = 1'b1;
        stored_params.rate_base = 16'h1234;
        repeat (12) @(posedge ref_clk);
        #1 arst_n = 1'b1;
        t_view();
        t_wrong();
        t_select();
        t_idle();
        t_prog();
        final_report();
    end
endmodule
